// >>> rtl/drive_regs_pkg.sv
package drive_regs_pkg;

  // register indices; byte address is four times the index
  localparam int NUM_REGS = 18;
  localparam logic [9:0] IDX_RAMP_SWITCH_METHOD    = 10'h07C;
  localparam logic [9:0] IDX_RAMP_SWITCH_METHOD_M2 = 10'h07D;
  localparam logic [9:0] IDX_ACCEL_TRANSITION      = 10'h07E;
  localparam logic [9:0] IDX_ACCEL_TRANSITION_M2   = 10'h07F;
  localparam logic [9:0] IDX_DECEL_TRANSITION      = 10'h080;
  localparam logic [9:0] IDX_DECEL_TRANSITION_M2   = 10'h081;
  localparam logic [9:0] IDX_ACCEL_CURVE_SHAPE     = 10'h082;
  localparam logic [9:0] IDX_DECEL_CURVE_SHAPE     = 10'h083;
  localparam logic [9:0] IDX_CUR_IN_START_FREQ     = 10'h084;
  localparam logic [9:0] IDX_CUR_IN_END_FREQ       = 10'h085;
  localparam logic [9:0] IDX_CUR_IN_START_PCT      = 10'h086;
  localparam logic [9:0] IDX_CUR_IN_END_PCT        = 10'h087;
  localparam logic [9:0] IDX_CUR_IN_START_MODE     = 10'h088;
  localparam logic [9:0] IDX_CALC_OPERAND_A_SRC    = 10'h0E3;
  localparam logic [9:0] IDX_CALC_OPERAND_B_SRC    = 10'h0E4;
  localparam logic [9:0] IDX_CALC_OPERATION        = 10'h0E5;
  localparam logic [9:0] IDX_OFFSET_FREQ_VALUE     = 10'h0E6;
  localparam logic [9:0] IDX_OFFSET_FREQ_DIR       = 10'h0E7;

  // slot numbers inside the register array
  localparam logic [4:0] S_METHOD = 5'h00, S_METHOD_M2 = 5'h01, S_ACC_TF = 5'h02;
  localparam logic [4:0] S_ACC_TF_M2 = 5'h03, S_DEC_TF = 5'h04, S_DEC_TF_M2 = 5'h05;
  localparam logic [4:0] S_ACC_SHAPE = 5'h06, S_DEC_SHAPE = 5'h07, S_CI_SFREQ = 5'h08;
  localparam logic [4:0] S_CI_EFREQ = 5'h09, S_CI_SPCT = 5'h0A, S_CI_EPCT = 5'h0B;
  localparam logic [4:0] S_CI_MODE = 5'h0C, S_SRC_A = 5'h0D, S_SRC_B = 5'h0E;
  localparam logic [4:0] S_CALC_OP = 5'h0F, S_OFS_VAL = 5'h10, S_OFS_DIR = 5'h11;

  localparam logic [NUM_REGS-1:0][9:0] REG_IDX = {
    IDX_OFFSET_FREQ_DIR, IDX_OFFSET_FREQ_VALUE, IDX_CALC_OPERATION,
    IDX_CALC_OPERAND_B_SRC, IDX_CALC_OPERAND_A_SRC, IDX_CUR_IN_START_MODE,
    IDX_CUR_IN_END_PCT, IDX_CUR_IN_START_PCT, IDX_CUR_IN_END_FREQ,
    IDX_CUR_IN_START_FREQ, IDX_DECEL_CURVE_SHAPE, IDX_ACCEL_CURVE_SHAPE,
    IDX_DECEL_TRANSITION_M2, IDX_DECEL_TRANSITION, IDX_ACCEL_TRANSITION_M2,
    IDX_ACCEL_TRANSITION, IDX_RAMP_SWITCH_METHOD_M2, IDX_RAMP_SWITCH_METHOD};

  localparam logic [15:0] MAX_CODE1 = 16'h0001;
  localparam logic [15:0] MAX_FREQ  = 16'h0FA0;
  localparam logic [15:0] MAX_PCT   = 16'h0064;
  localparam logic [15:0] MAX_SRC   = 16'h0004;
  localparam logic [15:0] MAX_OP    = 16'h0002;

  localparam logic [NUM_REGS-1:0][15:0] REG_MAX = {
    MAX_CODE1, MAX_FREQ, MAX_OP, MAX_SRC, MAX_SRC, MAX_CODE1,
    MAX_PCT, MAX_PCT, MAX_FREQ, MAX_FREQ, MAX_CODE1, MAX_CODE1,
    MAX_FREQ, MAX_FREQ, MAX_FREQ, MAX_FREQ, MAX_CODE1, MAX_CODE1};

  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [18:0] RAMP_TIME_LIMIT = 19'h02710;
  localparam logic [18:0] RAMP_TIME_STEP  = 19'h0000A;

  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL} calc_op_e;
  typedef enum logic [2:0] {SRC_OPERATOR, SRC_POT, SRC_VOLT, SRC_CURRENT, SRC_NET} src_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [NUM_REGS-1:0][15:0] regs;
    logic [31:0]               prdata;
    logic [1:0]                sw_sync;
    logic [1:0]                add_sync;
    logic                      second_ramp;
    logic [15:0]               cur_in_freq;
    logic [31:0]               calc_result;
    logic [16:0]               adj_freq;
    logic [18:0]               accel_time_eff;
    logic [18:0]               decel_time_eff;
  } state_s;

endpackage : drive_regs_pkg

// >>> rtl/drive_profile_regs.sv
// What this block does
// R01: each motor has a switch-method code, 0 to take the second ramp from the terminal, 1 at a frequency.
// R02: each motor stores the frequency, in 0.1 Hz up to 4000, where acceleration moves to ramp two.
// R03: each motor stores the frequency, in 0.1 Hz up to 4000, where deceleration moves to ramp two.
// R04: acceleration and deceleration each have a curve code, 0 linear and 1 S-shaped.
// R05: the current input keeps the frequency for the start of its active range, up to 4000.
// R06: the current input keeps the frequency for the end of its active range, up to 4000.
// R07: the start of the current-input active range is kept as a whole percent, 0 to 100.
// R08: the end of the current-input active range is kept as a whole percent, 0 to 100.
// R09: below the range start the output is the start frequency for code 0 or zero for code 1.
// R10: two source selectors pick operand A and B from panel, pot, voltage, current or network.
// R11: the calculate result is built from the two selected operands.
// R12: operation code 0 adds, 1 subtracts B from A, 2 multiplies.
// R13: the offset frequency, up to 4000, is applied only while the offset terminal is on.
// R14: offset direction 0 adds the offset to the frequency setting and 1 subtracts it.
// R15: a second ramp time of 10000 or more drops its second decimal digit.
// R16: a write outside a register's range is refused and leaves the stored value alone.
// R17: the master writes only legal codes and in-range values as 16-bit words; the test master also writes one past each maximum to check R16.
//
// Register access over APB was left to the implementer.
module drive_profile_regs
  import drive_regs_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // register bus
  input  wire apb_req_s    apb_req,
  output apb_rsp_s         apb_rsp,
  // digital terminals from pins
  input  wire logic        ramp_switch_terminal,
  input  wire logic        offset_add_terminal,
  // drive state from the motor control
  input  wire logic        motor2_sel,
  input  wire logic        accelerating,
  input  wire logic        decelerating,
  input  wire logic [15:0] output_freq,
  input  wire logic [15:0] freq_setting,
  input  wire logic [18:0] second_accel_time,
  input  wire logic [18:0] second_decel_time,
  // analog and operand sources
  input  wire logic [6:0]  current_in_pct,
  input  wire logic [15:0] operator_val,
  input  wire logic [15:0] pot_val,
  input  wire logic [15:0] volt_val,
  input  wire logic [15:0] net_val,
  // results
  output logic             second_ramp_active,
  output logic             accel_s_curve,
  output logic             decel_s_curve,
  output logic [15:0]      current_in_freq,
  output logic [31:0]      calc_result,
  output logic [16:0]      adjusted_freq,
  output logic [18:0]      accel_time_eff,
  output logic [18:0]      decel_time_eff
);

  state_s st_r;
  state_s st_nxt;

  logic        hit;
  logic [4:0]  sl;
  logic        setup_ph;
  logic        access_ph;
  logic        range_bad;
  logic        wr_ok;
  logic [15:0] method;
  logic [15:0] acc_tf;
  logic [15:0] dec_tf;
  logic [15:0] opa;
  logic [15:0] opb;
  logic signed [16:0] fspan;
  logic [7:0]  pspan;
  logic signed [25:0] prod;
  logic signed [25:0] quot;

  function automatic logic [15:0] pick_src(input logic [15:0] code,
                                           input logic [15:0] cur);
    logic [15:0] v;
    v = 16'h0000;
    case (src_e'(code[2:0]))
      SRC_OPERATOR: v = operator_val;
      SRC_POT:      v = pot_val;
      SRC_VOLT:     v = volt_val;
      SRC_CURRENT:  v = cur;
      SRC_NET:      v = net_val;
      default:      v = 16'h0000;
    endcase
    return v;
  endfunction : pick_src

  // a long time rounds down to whole tenths
  function automatic logic [18:0] trim_time(input logic [18:0] t);
    logic [18:0] r;
    r = t;
    if (t >= RAMP_TIME_LIMIT) begin
      r = t - (t % RAMP_TIME_STEP); // R15
    end
    return r;
  endfunction : trim_time

  always_comb begin
    hit = 1'b0;
    sl  = 5'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (apb_req.paddr[11:2] == REG_IDX[i]) begin
        hit = 1'b1;
        sl  = 5'(i);
      end
    end
  end

  assign setup_ph  = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign range_bad = apb_req.pwdata[15:0] > REG_MAX[sl];
  assign wr_ok     = access_ph && apb_req.pwrite && hit && !range_bad; // R16 R17

  // active motor's settings
  assign method = motor2_sel ? st_r.regs[S_METHOD_M2] : st_r.regs[S_METHOD]; // R01
  assign acc_tf = motor2_sel ? st_r.regs[S_ACC_TF_M2] : st_r.regs[S_ACC_TF]; // R02
  assign dec_tf = motor2_sel ? st_r.regs[S_DEC_TF_M2] : st_r.regs[S_DEC_TF]; // R03

  // process form so the source pins read inside the function wake it up
  always_comb begin
    opa = pick_src(st_r.regs[S_SRC_A], st_r.cur_in_freq); // R10
    opb = pick_src(st_r.regs[S_SRC_B], st_r.cur_in_freq); // R10
  end

  // linear interpolation across the active range
  assign fspan = $signed({1'b0, st_r.regs[S_CI_EFREQ]}) - $signed({1'b0, st_r.regs[S_CI_SFREQ]});
  assign pspan = st_r.regs[S_CI_EPCT][7:0] - st_r.regs[S_CI_SPCT][7:0];
  assign prod  = 26'(fspan) * $signed({18'h00000, 1'b0, current_in_pct - st_r.regs[S_CI_SPCT][6:0]});
  assign quot  = (pspan == 8'h00) ? 26'h0000000 : prod / $signed({18'h00000, pspan});

  always_comb begin
    st_nxt = st_r;
    // second stage only feeds from the first
    st_nxt.sw_sync  = {st_r.sw_sync[0], ramp_switch_terminal};
    st_nxt.add_sync = {st_r.add_sync[0], offset_add_terminal};

    if (setup_ph) begin
      st_nxt.prdata = hit ? {16'h0000, st_r.regs[sl]} : 32'h00000000;
    end
    if (wr_ok) begin
      st_nxt.regs[sl] = apb_req.pwdata[15:0]; // R02 R03 R05 R06 R07 R08 R13
    end

    // profile switch
    if (method[0] == 1'b0) begin
      st_nxt.second_ramp = st_r.sw_sync[1]; // R01
    end else if (accelerating) begin
      st_nxt.second_ramp = output_freq >= acc_tf; // R02
    end else if (decelerating) begin
      st_nxt.second_ramp = output_freq <= dec_tf; // R03
    end else begin
      st_nxt.second_ramp = 1'b0;
    end

    // current input scaling
    if ({9'h000, current_in_pct} < st_r.regs[S_CI_SPCT]) begin
      st_nxt.cur_in_freq = st_r.regs[S_CI_MODE][0] ? 16'h0000 : st_r.regs[S_CI_SFREQ]; // R09
    end else if ({9'h000, current_in_pct} >= st_r.regs[S_CI_EPCT]) begin
      st_nxt.cur_in_freq = st_r.regs[S_CI_EFREQ]; // R06 R08
    end else begin
      st_nxt.cur_in_freq = 16'(quot + 26'(st_r.regs[S_CI_SFREQ])); // R05 R07
    end

    // calculate function
    case (calc_op_e'(st_r.regs[S_CALC_OP][1:0]))
      OP_ADD:  st_nxt.calc_result = {16'h0000, opa} + {16'h0000, opb}; // R11 R12
      OP_SUB:  st_nxt.calc_result = {16'h0000, opa} - {16'h0000, opb}; // R12
      OP_MUL:  st_nxt.calc_result = {16'h0000, opa} * {16'h0000, opb}; // R12
      default: st_nxt.calc_result = 32'h00000000;
    endcase

    // offset; a subtraction below zero clamps
    if (!st_r.add_sync[1]) begin
      st_nxt.adj_freq = {1'b0, freq_setting}; // R13
    end else if (st_r.regs[S_OFS_DIR][0] == 1'b0) begin
      st_nxt.adj_freq = {1'b0, freq_setting} + {1'b0, st_r.regs[S_OFS_VAL]}; // R14
    end else if (freq_setting >= st_r.regs[S_OFS_VAL]) begin
      st_nxt.adj_freq = {1'b0, freq_setting - st_r.regs[S_OFS_VAL]}; // R14
    end else begin
      st_nxt.adj_freq = 17'h00000;
    end

    st_nxt.accel_time_eff = trim_time(second_accel_time);
    st_nxt.decel_time_eff = trim_time(second_decel_time);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r.regs           <= {NUM_REGS{REG_RESET}};
      st_r.prdata         <= 32'h00000000;
      st_r.sw_sync        <= 2'h0;
      st_r.add_sync       <= 2'h0;
      st_r.second_ramp    <= 1'b0;
      st_r.cur_in_freq    <= 16'h0000;
      st_r.calc_result    <= 32'h00000000;
      st_r.adj_freq       <= 17'h00000;
      st_r.accel_time_eff <= 19'h00000;
      st_r.decel_time_eff <= 19'h00000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero-wait access: read data was latched during setup
  assign apb_rsp.prdata  = st_r.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access_ph && (!hit || (apb_req.pwrite && range_bad)); // R16

  assign second_ramp_active = st_r.second_ramp;
  assign accel_s_curve      = st_r.regs[S_ACC_SHAPE][0]; // R04
  assign decel_s_curve      = st_r.regs[S_DEC_SHAPE][0]; // R04
  assign current_in_freq    = st_r.cur_in_freq;
  assign calc_result        = st_r.calc_result;
  assign adjusted_freq      = st_r.adj_freq;
  assign accel_time_eff     = st_r.accel_time_eff;
  assign decel_time_eff     = st_r.decel_time_eff;

  a_term_switch: assert property (@(posedge mclk) disable iff (reset) // R01
    (method[0] == 1'b0 && st_r.sw_sync[1]) |=> second_ramp_active)
    else $error("terminal method did not select second ramp");

  a_accel_point: assert property (@(posedge mclk) disable iff (reset) // R02
    (method[0] && accelerating && output_freq < acc_tf) |=> !second_ramp_active)
    else $error("second accel ramp below transition point");

  a_decel_point: assert property (@(posedge mclk) disable iff (reset) // R03
    (method[0] && !accelerating && decelerating && output_freq <= dec_tf)
    |=> second_ramp_active)
    else $error("second decel ramp missed at transition point");

  a_range_reject: assert property (@(posedge mclk) disable iff (reset) // R16
    (access_ph && apb_req.pwrite && hit && range_bad)
    |=> st_r.regs[$past(sl)] == $past(st_r.regs[sl]))
    else $error("out of range write changed a register");

  a_write_store: assert property (@(posedge mclk) disable iff (reset) // R07
    wr_ok |=> st_r.regs[$past(sl)] == $past(apb_req.pwdata[15:0]))
    else $error("valid write not stored");

  a_below_zero: assert property (@(posedge mclk) disable iff (reset) // R09
    ({9'h000, current_in_pct} < st_r.regs[S_CI_SPCT] && st_r.regs[S_CI_MODE][0]
     && $stable(st_r.regs[S_CI_MODE])) |=> current_in_freq == 16'h0000)
    else $error("below range start did not give zero");

  a_calc_sum: assert property (@(posedge mclk) disable iff (reset) // R12
    (st_r.regs[S_CALC_OP][1:0] == 2'h0)
    |=> calc_result == {16'h0000, $past(opa)} + {16'h0000, $past(opb)})
    else $error("add result wrong");

  a_offset_idle: assert property (@(posedge mclk) disable iff (reset) // R13
    !st_r.add_sync[1] |=> adjusted_freq == {1'b0, $past(freq_setting)})
    else $error("offset applied with terminal off");

  a_offset_plus: assert property (@(posedge mclk) disable iff (reset) // R14
    (st_r.add_sync[1] && st_r.regs[S_OFS_DIR][0] == 1'b0)
    |=> adjusted_freq == {1'b0, $past(freq_setting)} + {1'b0, $past(st_r.regs[S_OFS_VAL])})
    else $error("plus offset wrong");

  a_time_trim: assert property (@(posedge mclk) disable iff (reset) // R15
    (second_accel_time >= RAMP_TIME_LIMIT) |=> (accel_time_eff % RAMP_TIME_STEP) == 19'h00000)
    else $error("long ramp time kept its second decimal");

  a_motor2_term: assert property (@(posedge mclk) disable iff (reset) // R01
    (motor2_sel && st_r.regs[S_METHOD_M2][0] == 1'b0 && st_r.sw_sync[1])
    |=> second_ramp_active)
    else $error("motor two terminal method ignored");

  a_term_off: assert property (@(posedge mclk) disable iff (reset) // R01
    (method[0] == 1'b0 && !st_r.sw_sync[1])
    |=> !second_ramp_active)
    else $error("second ramp with terminal off");

  a_steady_first: assert property (@(posedge mclk) disable iff (reset) // R01
    (method[0] && !accelerating && !decelerating)
    |=> !second_ramp_active)
    else $error("second ramp at steady speed");

  a_accel_reach: assert property (@(posedge mclk) disable iff (reset) // R02
    (method[0] && accelerating && output_freq >= acc_tf)
    |=> second_ramp_active)
    else $error("second accel ramp missed at transition point");

  a_decel_above: assert property (@(posedge mclk) disable iff (reset) // R03
    (method[0] && !accelerating && decelerating && output_freq > dec_tf)
    |=> !second_ramp_active)
    else $error("second decel ramp above transition point");

  a_accel_shape: assert property (@(posedge mclk) disable iff (reset) // R04
    (wr_ok && sl == S_ACC_SHAPE)
    |=> accel_s_curve == $past(apb_req.pwdata[0]))
    else $error("accel curve code not shown");

  a_decel_shape: assert property (@(posedge mclk) disable iff (reset) // R04
    (wr_ok && sl == S_DEC_SHAPE)
    |=> decel_s_curve == $past(apb_req.pwdata[0]))
    else $error("decel curve code not shown");

  a_sfreq_range: assert property (@(posedge mclk) disable iff (reset) // R05
    st_r.regs[S_CI_SFREQ] <= MAX_FREQ)
    else $error("start frequency out of range");

  a_efreq_range: assert property (@(posedge mclk) disable iff (reset) // R06
    st_r.regs[S_CI_EFREQ] <= MAX_FREQ)
    else $error("end frequency out of range");

  a_end_freq: assert property (@(posedge mclk) disable iff (reset) // R06
    ({9'h000, current_in_pct} >= st_r.regs[S_CI_SPCT]
     && {9'h000, current_in_pct} >= st_r.regs[S_CI_EPCT])
    |=> current_in_freq == $past(st_r.regs[S_CI_EFREQ]))
    else $error("above range end did not give end frequency");

  a_spct_range: assert property (@(posedge mclk) disable iff (reset) // R07
    st_r.regs[S_CI_SPCT] <= MAX_PCT)
    else $error("start percent out of range");

  a_epct_range: assert property (@(posedge mclk) disable iff (reset) // R08
    st_r.regs[S_CI_EPCT] <= MAX_PCT)
    else $error("end percent out of range");

  a_start_freq: assert property (@(posedge mclk) disable iff (reset) // R09
    ({9'h000, current_in_pct} < st_r.regs[S_CI_SPCT] && !st_r.regs[S_CI_MODE][0])
    |=> current_in_freq == $past(st_r.regs[S_CI_SFREQ]))
    else $error("below range start did not give start frequency");

  a_src_range: assert property (@(posedge mclk) disable iff (reset) // R10
    st_r.regs[S_SRC_A] <= MAX_SRC && st_r.regs[S_SRC_B] <= MAX_SRC)
    else $error("operand source code out of range");

  a_src_net: assert property (@(posedge mclk) disable iff (reset) // R10
    (st_r.regs[S_SRC_A][2:0] == 3'h4) |-> opa == net_val)
    else $error("network source not picked");

  a_src_cur: assert property (@(posedge mclk) disable iff (reset) // R11
    (st_r.regs[S_SRC_B][2:0] == 3'h3) |-> opb == st_r.cur_in_freq)
    else $error("current source not picked");

  a_op_range: assert property (@(posedge mclk) disable iff (reset) // R12
    st_r.regs[S_CALC_OP] <= MAX_OP)
    else $error("operation code out of range");

  a_calc_diff: assert property (@(posedge mclk) disable iff (reset) // R12
    (st_r.regs[S_CALC_OP][1:0] == 2'h1)
    |=> calc_result == {16'h0000, $past(opa)} - {16'h0000, $past(opb)})
    else $error("subtract result wrong");

  a_calc_prod: assert property (@(posedge mclk) disable iff (reset) // R12
    (st_r.regs[S_CALC_OP][1:0] == 2'h2)
    |=> calc_result == {16'h0000, $past(opa)} * {16'h0000, $past(opb)})
    else $error("multiply result wrong");

  a_ofs_range: assert property (@(posedge mclk) disable iff (reset) // R13
    st_r.regs[S_OFS_VAL] <= MAX_FREQ)
    else $error("offset value out of range");

  a_offset_minus: assert property (@(posedge mclk) disable iff (reset) // R14
    (st_r.add_sync[1] && st_r.regs[S_OFS_DIR][0] && freq_setting >= st_r.regs[S_OFS_VAL])
    |=> adjusted_freq == {1'b0, $past(freq_setting) - $past(st_r.regs[S_OFS_VAL])})
    else $error("minus offset wrong");

  a_offset_clamp: assert property (@(posedge mclk) disable iff (reset) // R14
    (st_r.add_sync[1] && st_r.regs[S_OFS_DIR][0] && freq_setting < st_r.regs[S_OFS_VAL])
    |=> adjusted_freq == 17'h00000)
    else $error("minus offset did not clamp");

  a_decel_trim: assert property (@(posedge mclk) disable iff (reset) // R15
    (second_decel_time >= RAMP_TIME_LIMIT)
    |=> (decel_time_eff % RAMP_TIME_STEP) == 19'h00000)
    else $error("long decel time kept its second decimal");

  a_short_time: assert property (@(posedge mclk) disable iff (reset) // R15
    (second_accel_time < RAMP_TIME_LIMIT)
    |=> accel_time_eff == $past(second_accel_time))
    else $error("short ramp time altered");

  a_unmapped_read: assert property (@(posedge mclk) disable iff (reset) // R16
    (setup_ph && !hit)
    |=> apb_rsp.prdata == 32'h00000000)
    else $error("unmapped read gave data");

  a_read_upper: assert property (@(posedge mclk) disable iff (reset) // R17
    apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

endmodule : drive_profile_regs

// >>> test/drive_master_model.sv
module drive_master_model
  import drive_regs_pkg::*;
(
  // clock
  input  wire logic     mclk,
  // register bus
  output apb_req_s      apb_req,
  input  wire apb_rsp_s apb_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial apb_req = '0;

  // one setup cycle, then access until pready; idle cycle between transfers
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [15:0] data);
    int n;
    @(posedge mclk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= addr;
    apb_req.pwdata  <= {16'h0000, data};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 64);
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    // released data must not look like the last value
    apb_req.pwdata  <= ~apb_req.pwdata;
  endtask : xfer
endmodule : drive_master_model

// >>> test/drive_profile_and_calc_params_tb_top.sv
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end

module drive_profile_and_calc_params_tb_top
  import drive_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  apb_req_s    apb_req;
  apb_rsp_s    apb_rsp;
  logic        sw_pin, ofs_pin, m2, acc, dec, sra, acc_s, dec_s;
  logic [15:0] ofreq, fset, opv, potv, voltv, netv, cif, v;
  logic [18:0] t_acc, t_dec, tae, tde;
  logic [6:0]  pct;
  logic [31:0] cres, a, b;
  logic [16:0] adj;
  logic [33:0] exp_q[$];
  logic [33:0] mon_e;
  logic [15:0] srcv [5];
  int          n_fail = 0;
  int          check_count = 0;
  logic [20:0] sw_tbl [6] = '{{3'h2, 1'b0, 16'h07D0, 1'b1}, {3'h2, 1'b0, 16'h07CF, 1'b0},
    {3'h1, 1'b0, 16'h03E8, 1'b1}, {3'h1, 1'b0, 16'h03E9, 1'b0},
    {3'h6, 1'b1, 16'h0000, 1'b1}, {3'h6, 1'b0, 16'h0000, 1'b0}};
  logic [23:0] ci_tbl [4] = '{{1'b0, 7'h0A, 16'h03E8}, {1'b0, 7'h5A, 16'h0BB8},
    {1'b0, 7'h46, 16'h07D0}, {1'b1, 7'h0A, 16'h0000}};
  logic [34:0] of_tbl [4] = '{{2'h0, 16'h04B0, 17'h004B0}, {2'h1, 16'h04B0, 17'h006A4},
    {2'h3, 16'h04B0, 17'h002BC}, {2'h3, 16'h012C, 17'h00000}};
  logic [18:0] tm_tbl [3] = '{19'h03039, 19'h02710, 19'h0270F};

  drive_profile_regs dut (.mclk(mclk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ramp_switch_terminal(sw_pin), .offset_add_terminal(ofs_pin), .motor2_sel(m2),
    .accelerating(acc), .decelerating(dec), .output_freq(ofreq), .freq_setting(fset),
    .second_accel_time(t_acc), .second_decel_time(t_dec), .current_in_pct(pct),
    .operator_val(opv), .pot_val(potv), .volt_val(voltv), .net_val(netv),
    .second_ramp_active(sra), .accel_s_curve(acc_s), .decel_s_curve(dec_s),
    .current_in_freq(cif), .calc_result(cres), .adjusted_freq(adj),
    .accel_time_eff(tae), .decel_time_eff(tde));

  drive_master_model mdl (.mclk(mclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  initial forever #4 mclk = ~mclk;

  function automatic logic [11:0] ra(input int s);
    return {REG_IDX[s], 2'b00};
  endfunction : ra

  function automatic logic [18:0] trim(input logic [18:0] x);
    return (x >= 19'h02710) ? x - x % 10 : x;
  endfunction : trim

  task automatic wr(input logic [11:0] ad, input logic [15:0] d, input logic err);
    exp_q.push_back({1'b0, err, 32'h0000_0000});
    mdl.xfer(1'b1, ad, d);
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [15:0] e, input logic err);
    exp_q.push_back({1'b1, err, 16'h0000, e});
    mdl.xfer(1'b0, ad, 16'h0000);
  endtask : rd

  // terminals need two sync edges plus the result register chain
  task automatic settle;
    repeat (6) @(posedge mclk);
    #1;
  endtask : settle

  task automatic conclude;
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  always @(posedge mclk) begin
    if (apb_req.psel === 1'b1 && apb_req.penable === 1'b1 && apb_rsp.pready === 1'b1) begin
      mon_e = exp_q.pop_front();
      `CHK("pslverr", mon_e[32], apb_rsp.pslverr)
      if (mon_e[33]) `CHK("prdata", mon_e[31:0], apb_rsp.prdata)
    end
  end

  initial begin
    #100000;
    n_fail++;
    conclude();
  end

  initial begin
    {sw_pin, ofs_pin, m2, acc, dec, ofreq, fset, pct, t_acc, t_dec} = '0;
    void'($urandom(32'h6e8a130d));
    {opv, potv, voltv, netv} = {$urandom, $urandom};
    srcv = '{opv, potv, voltv, 16'h0BB8, netv};
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) rd(ra(i), 16'h0000, 1'b0);
    for (int i = 0; i < NUM_REGS; i++) begin
      v = 16'($urandom_range(REG_MAX[i]));
      wr(ra(i), v, 1'b0);
      rd(ra(i), v, 1'b0);
      wr(ra(i), REG_MAX[i] + 16'h0001, 1'b1);
      rd(ra(i), v, 1'b0);
    end
    wr(12'h000, 16'h0001, 1'b1);
    rd(12'h000, 16'h0000, 1'b1);
    wr(ra(S_METHOD), 16'h0001, 1'b0);
    wr(ra(S_METHOD_M2), 16'h0000, 1'b0);
    wr(ra(S_ACC_TF), 16'h07D0, 1'b0);
    wr(ra(S_DEC_TF), 16'h03E8, 1'b0);
    wr(ra(S_ACC_SHAPE), 16'h0001, 1'b0);
    wr(ra(S_DEC_SHAPE), 16'h0000, 1'b0);
    settle();
    `CHK("accel_s_curve", 1'b1, acc_s)
    `CHK("decel_s_curve", 1'b0, dec_s)
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      {m2, acc, dec, sw_pin, ofreq} <= sw_tbl[i][20:1];
      settle();
      `CHK("second_ramp_active", sw_tbl[i][0], sra)
    end
    wr(ra(S_CI_SFREQ), 16'h03E8, 1'b0);
    wr(ra(S_CI_EFREQ), 16'h0BB8, 1'b0);
    wr(ra(S_CI_SPCT), 16'h003C, 1'b0);
    wr(ra(S_CI_EPCT), 16'h0050, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(ra(S_CI_MODE), {15'h0000, ci_tbl[i][23]}, 1'b0);
      @(posedge mclk);
      pct <= ci_tbl[i][22:16];
      settle();
      `CHK("current_in_freq", ci_tbl[i][15:0], cif)
    end
    @(posedge mclk);
    pct <= 7'h5A;
    for (int op = 0; op < 3; op++) begin
      for (int sa = 0; sa < 5; sa++) begin
        wr(ra(S_SRC_A), 16'(sa), 1'b0);
        wr(ra(S_SRC_B), 16'((sa + 2) % 5), 1'b0);
        wr(ra(S_CALC_OP), 16'(op), 1'b0);
        settle();
        a = {16'h0000, srcv[sa]};
        b = {16'h0000, srcv[(sa + 2) % 5]};
        `CHK("calc_result", (op == 0) ? a + b : (op == 1) ? a - b : a * b, cres)
      end
    end
    wr(ra(S_OFS_VAL), 16'h01F4, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(ra(S_OFS_DIR), {15'h0000, of_tbl[i][34]}, 1'b0);
      @(posedge mclk);
      {ofs_pin, fset} <= of_tbl[i][33:17];
      settle();
      `CHK("adjusted_freq", of_tbl[i][16:0], adj)
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      t_acc <= tm_tbl[i];
      t_dec <= tm_tbl[i] + 19'h00003;
      settle();
      `CHK("accel_time_eff", trim(tm_tbl[i]), tae)
      `CHK("decel_time_eff", trim(tm_tbl[i] + 19'h00003), tde)
    end
    conclude();
  end
endmodule : drive_profile_and_calc_params_tb_top
